// ---- logic/fes_defs.svh ----
/*
 * Constants for the exception and status unit: instruction field positions,
 * opcode codes, status word width and floating point encodings.
 * Assumes single precision operands of 32 bits and an 11-bit instruction.
 */
`ifndef FES_DEFS_SVH
`define FES_DEFS_SVH

`define FES_INSTR_W 11
`define FES_DATA_W 32
`define FES_EXP_MSB 30
`define FES_EXP_LSB 23
`define FES_FRAC_MSB 22
`define FES_SIGN_BIT 31
`define FES_OUT_SRC_BIT 6
`define FES_A_PREC_BIT 8
`define FES_B_PREC_BIT 7
`define FES_A_MAG_BIT 4
`define FES_INT_FMT_BIT 9
`define FES_UNIT_MSB 6
`define FES_UNIT_LSB 5
`define FES_SINGLE_OP_UNIT 2'h1
`define FES_TWO_OP_UNIT 2'h0
`define FES_MUL_UNIT 2'h2
`define FES_DIV_UNIT 2'h3
`define FES_OP_PASS_A 4'h0
`define FES_OP_NEG_A 4'h1
`define FES_OP_INT_TO_FLT 4'h2
`define FES_OP_FLT_TO_INT 4'h3
`define FES_OP_MOVE_A 4'h4
`define FES_OP_PASS_B 4'h5
`define FES_OP_PREC_CONV 4'h6
`define FES_OP_FLT_TO_UNS 4'h7
`define FES_OP_WRAP 4'h8
`define FES_OP_UNS_TO_FLT 4'hA
`define FES_OP_UNWRAP_EX 4'hC
`define FES_OP_UNWRAP_IN 4'hD
`define FES_OP_UNWRAP_RND 4'hE
`define FES_OP_ADD 4'h0
`define FES_OP_SUB 4'h1
`define FES_OP_SUB_BA 4'h3
`define FES_NAN_OUT 32'h7FFFFFFF
`define FES_INF_EXP 8'hFF
`define FES_VIEW_FOLLOW 2'h3
`define FES_VIEW_ALU 2'h1
`define FES_VIEW_MUL 2'h2
`define FES_STATUS_W 14

`endif

// ---- logic/fes_pkg.sv ----
/*
 * Types shared by both ends of the exception and status link.
 * Assumes fes_defs.svh is on the include path.
 */
`include "fes_defs.svh"
package fes_pkg;
    // One unit's status word, held in a fixed bit order
    typedef struct packed {
        logic tiny_or_wrapped_flag;
        logic rounded_up_flag;
        logic rounding_carry_flag;
        logic too_large_flag;
        logic too_small_flag;
        logic unbounded_result_flag;
        logic invalid_flag;
        logic zero_divisor_flag;
        logic subnormal_input_flag;
        logic [1:0] faulting_port_code;
        logic equal_zero_flag;
        logic sign_flag;
        logic any_exception;
    } fes_status_t;

    typedef enum logic [1:0] {
        FES_CTL_IDLE = 2'h0,
        FES_CTL_ISSUE = 2'h1,
        FES_CTL_READ = 2'h2
    } fes_ctl_state_t;
endpackage

// ---- logic/fes_link_if.sv ----
/*
 * Link between the microcoded controller and the exception unit.
 * Status outputs are driven by the device with an output enable; the
 * interface resolves the shared status bus.
 */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
interface fes_link_if;
    import fes_pkg::*;
    logic [`FES_INSTR_W-1:0] instruction;
    logic [`FES_DATA_W-1:0] port_a_input;
    logic [`FES_DATA_W-1:0] port_b_input;
    logic [1:0] status_view_select;
    logic output_pipe_bypass;
    logic status_output_enable_n;
    logic compare_output_enable_n;
    logic [`FES_DATA_W-1:0] result;
    fes_status_t status_drive;
    logic status_drive_en;
    logic hidden_source_exception;
    logic result_origin_flag;
    fes_status_t status_bus;

    assign status_bus = status_drive_en ? status_drive : '0;

    modport device (
        input instruction, port_a_input, port_b_input, status_view_select,
        input output_pipe_bypass, status_output_enable_n,
        input compare_output_enable_n,
        output result, status_drive, status_drive_en,
        output hidden_source_exception, result_origin_flag
    );
    modport controller (
        output instruction, port_a_input, port_b_input, status_view_select,
        output output_pipe_bypass, status_output_enable_n,
        output compare_output_enable_n,
        input result, status_bus, hidden_source_exception,
        input result_origin_flag
    );
endinterface
`default_nettype wire

// ---- logic/fes_special_vals.sv ----
/*
 * Classifies one single precision operand: zero, infinity, NaN, denormal.
 * Purely combinational; used once per operand port.
 */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
module fes_special_vals
    import fes_pkg::*;
(
    input wire logic [`FES_DATA_W-1:0] i_value,
    output logic o_zero,
    output logic o_inf,
    output logic o_nan,
    output logic o_tiny_or_wrapped_flag
);
    wire [7:0] exp_field = i_value[`FES_EXP_MSB:`FES_EXP_LSB];
    wire frac_nz = |i_value[`FES_FRAC_MSB:0];
    wire exp_ones = (exp_field == `FES_INF_EXP);
    wire exp_zero = (exp_field == 8'h00);
    assign o_zero = exp_zero && !frac_nz;
    assign o_inf = exp_ones && !frac_nz;
    assign o_nan = exp_ones && frac_nz;
    assign o_tiny_or_wrapped_flag = exp_zero && frac_nz;
endmodule // fes_special_vals
`default_nettype wire

// ---- logic/fes_device.sv ----
/*
 * Device end: ALU and multiplier special-value results, exception flags,
 * status source selection, status register and enable gating.
 * Assumes the controller keeps its own operand and enable conventions.
 * Finite arithmetic is a simplified single precision model: only special
 * values are tracked exactly; rounding direction and range are approximated.
 */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
// Overview of operation
// - Origin flag shows selected unit every result
// - Hidden-source flag on deselected unit exception
// - Too-large above range, too-small below range
// - Rounded-up when ALU magnitude increased
// - Tiny flag: wrapped, denormal, illegal integer
// - Denormal plus rounded-up also raises too-small
// - View select both high follows source bit
// - View select forces ALU or multiplier status
// - Status registered only when pipe bypass low
// - Controller pulls an enable low to read
// - Integer zero, sign, overflow flags
// - Invalid on bad op or a NaN on a used port, not on Move-A
// - Zero-divisor and subnormal-input flags
// - Faulting port code names A, B, both
// - Output NaN is all-ones fraction, sign zero
// - Move-A passes operand with no flags
// - Divide by zero: NaN or signed infinity
// - Signed zero products, zero sum sign rules
// - Infinity division results and invalid case
// - Infinity times zero, cancelling sums invalid
// - Infinity and zero encodings, infinity flag
// - Single-operand opcode map
// - Controller keeps precision bits equal on floating single-operand ops
module fes_device
    import fes_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    fes_link_if.device link
);
    logic [`FES_INSTR_W-1:0] ins;
    logic [`FES_DATA_W-1:0] a;
    logic [`FES_DATA_W-1:0] b;
    assign ins = link.instruction;
    assign a = link.port_a_input;
    assign b = link.port_b_input;

    logic a_zero, a_inf, a_nan, a_den, b_zero, b_inf, b_nan, b_den;
    fes_special_vals u_cls_a (
        .i_value(a), .o_zero(a_zero), .o_inf(a_inf), .o_nan(a_nan),
        .o_tiny_or_wrapped_flag(a_den)
    );
    fes_special_vals u_cls_b (
        .i_value(b), .o_zero(b_zero), .o_inf(b_inf), .o_nan(b_nan),
        .o_tiny_or_wrapped_flag(b_den)
    );

    function automatic logic [1:0] port_code(input logic fa, input logic fb);
        port_code = {fb, fa};
    endfunction

    function automatic logic [`FES_DATA_W-1:0] inf_of(input logic s);
        inf_of = {s, `FES_INF_EXP, 23'h000000};
    endfunction

    wire is_int = ins[`FES_INT_FMT_BIT];
    wire [1:0] unit = ins[`FES_UNIT_MSB:`FES_UNIT_LSB];
    wire [3:0] op = ins[3:0];
    wire mag_a = ins[`FES_A_MAG_BIT];
    wire out_src = ins[`FES_OUT_SRC_BIT];
    wire single_op = (unit == `FES_SINGLE_OP_UNIT);
    wire is_move = !is_int && single_op && op == `FES_OP_MOVE_A;
    wire sa = a[`FES_SIGN_BIT] & ~mag_a;
    wire sb = b[`FES_SIGN_BIT];

    // ALU path: special values, add/sub and single-operand ops
    // B - A flips the sign of A only, so B keeps its own sign there
    wire neg_b = !single_op && op[1:0] == 2'h1;
    wire eff_sb = sb ^ neg_b;
    wire eff_sa = sa ^ (op[1:0] == 2'h3 && !single_op);
    wire uses_b = !single_op || op == `FES_OP_PASS_B;
    wire alu_nan_in = !is_move && (a_nan || (uses_b && b_nan));
    wire inf_cancel = !single_op && a_inf && b_inf && (eff_sa != eff_sb);
    wire alu_inval = alu_nan_in || inf_cancel;
    logic [`FES_DATA_W-1:0] alu_res;
    logic alu_illegal_int;
    logic [8:0] alu_sum_exp;
    always_comb begin
        alu_illegal_int = 1'b0;
        alu_sum_exp = {1'b0, a[`FES_EXP_MSB:`FES_EXP_LSB]} + 9'h001;
        if (is_move) begin
            alu_res = a;
        end else if (alu_inval) begin
            alu_res = `FES_NAN_OUT;
        end else if (single_op) begin
            unique case (op)
                `FES_OP_PASS_A: alu_res = {sa, a[30:0]};
                `FES_OP_NEG_A: alu_res = {~sa, a[30:0]};
                `FES_OP_PASS_B: alu_res = b;
                default: alu_res = {sa, a[30:0]};
            endcase
            alu_illegal_int = is_int && (op == `FES_OP_WRAP);
        end else if (a_inf || b_inf) begin
            alu_res = inf_of(a_inf ? eff_sa : eff_sb);
        end else if (a_zero && b_zero) begin
            alu_res = {eff_sa & eff_sb, 31'h0};
        end else if (a_zero) begin
            alu_res = {eff_sb, b[30:0]};
        end else if (b_zero) begin
            alu_res = {eff_sa, a[30:0]};
        end else begin
            alu_res = {eff_sa, a[30:0]};
        end
    end
    // Equal-magnitude doubling rounds up when B's LSB is set; crude range model of a sum
    wire alu_same = !single_op && !alu_inval && !a_inf && !b_inf &&
        a[30:0] == b[30:0] && eff_sa == eff_sb && !a_zero;
    wire alu_over = alu_same && alu_sum_exp[7:0] == `FES_INF_EXP;
    wire alu_round = alu_same && b[0];
    wire alu_den_out = !is_move && !alu_inval && alu_res[30:23] == 8'h00 &&
        |alu_res[22:0];
    wire alu_inf_out = !is_move && alu_res[30:0] == {`FES_INF_EXP, 23'h0};

    fes_status_t alu_st;
    always_comb begin
        alu_st = '0;
        if (!is_move) begin
            alu_st.invalid_flag = alu_inval;
            alu_st.faulting_port_code = alu_nan_in ?
                port_code(a_nan, uses_b && b_nan) : 2'h0;
            alu_st.too_large_flag = alu_over;
            alu_st.rounded_up_flag = alu_round;
            alu_st.tiny_or_wrapped_flag = alu_den_out || alu_illegal_int;
            alu_st.too_small_flag = alu_den_out && alu_round;
            alu_st.unbounded_result_flag = alu_inf_out || alu_over;
            alu_st.equal_zero_flag = alu_res[30:0] == 31'h0;
            alu_st.sign_flag = alu_res[`FES_SIGN_BIT];
        end
        alu_st.any_exception = alu_st.invalid_flag || alu_st.too_large_flag ||
            alu_st.tiny_or_wrapped_flag || alu_st.rounded_up_flag;
    end

    // Multiplier path: multiply and divide special values
    wire is_div = (unit == `FES_DIV_UNIT);
    wire ps = a[`FES_SIGN_BIT] ^ sb ^ ins[2];
    wire mul_nan_in = a_nan || b_nan;
    wire div_zz = is_div && a_zero && b_zero;
    wire div_ii = is_div && a_inf && b_inf;
    wire mul_iz = !is_div && ((a_inf && b_zero) || (b_inf && a_zero));
    // Square root shares the divider slot; a negative radicand is invalid
    wire sqrt_neg = is_div && ins[3] && sa && !a_zero && !a_nan;
    wire mul_inval = mul_nan_in || div_zz || div_ii || mul_iz || sqrt_neg;
    wire div_by_zero = is_div && b_zero;
    logic [`FES_DATA_W-1:0] mul_res;
    always_comb begin
        if (mul_inval) begin
            mul_res = `FES_NAN_OUT;
        end else if (is_div && (b_zero || a_inf)) begin
            mul_res = inf_of(ps);
        end else if (is_div && b_inf) begin
            mul_res = {ps, 31'h0};
        end else if (!is_div && (a_inf || b_inf)) begin
            mul_res = inf_of(ps);
        end else if (!is_div && (a_zero || b_zero)) begin
            mul_res = {ps, 31'h0};
        end else begin
            mul_res = {ps, a[30:0]};
        end
    end
    wire [8:0] mul_exp = {1'b0, a[30:23]} + {1'b0, b[30:23]};
    wire mul_finite = !mul_inval && !a_inf && !b_inf && !a_zero && !b_zero &&
        !is_div;
    wire mul_over = mul_finite && mul_exp > 9'h17D;
    wire mul_under = mul_finite && mul_exp < 9'h07F;
    wire mul_wrap = mul_under || (!is_div && |ins[1:0]);
    fes_status_t mul_st;
    always_comb begin
        mul_st = '0;
        mul_st.invalid_flag = mul_inval;
        mul_st.zero_divisor_flag = div_by_zero;
        mul_st.subnormal_input_flag = a_den || b_den;
        mul_st.faulting_port_code = port_code(a_nan || a_den, b_nan || b_den);
        mul_st.too_large_flag = mul_over;
        mul_st.too_small_flag = mul_under;
        mul_st.tiny_or_wrapped_flag = mul_wrap;
        mul_st.rounded_up_flag = mul_wrap && a[0] && b[0];
        mul_st.rounding_carry_flag = mul_wrap && a[0] && b[0] && a[1];
        mul_st.unbounded_result_flag = mul_res[30:0] == {`FES_INF_EXP, 23'h0};
        mul_st.equal_zero_flag = mul_res[30:0] == 31'h0;
        mul_st.sign_flag = mul_res[`FES_SIGN_BIT];
        mul_st.any_exception = mul_inval || div_by_zero || mul_over ||
            mul_under || mul_wrap || mul_st.subnormal_input_flag;
    end

    // Source and status view selection
    wire [1:0] view = link.status_view_select;
    wire view_mul = (view == `FES_VIEW_FOLLOW) ? out_src :
        (view == `FES_VIEW_MUL);
    fes_status_t sel_st;
    assign sel_st = view_mul ? mul_st : alu_st;
    wire [`FES_DATA_W-1:0] sel_res = out_src ? mul_res : alu_res;
    wire hidden_ex = out_src ? alu_st.any_exception : mul_st.any_exception;

    fes_status_t st_reg;
    logic [`FES_DATA_W-1:0] res_reg;
    logic origin_reg, hidden_reg;
    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            st_reg <= '0;
            res_reg <= '0;
            origin_reg <= 1'b0;
            hidden_reg <= 1'b0;
        end else if (!link.output_pipe_bypass) begin
            st_reg <= sel_st;
            res_reg <= sel_res;
            origin_reg <= out_src;
            hidden_reg <= hidden_ex;
        end
    end

    wire bypass = link.output_pipe_bypass;
    wire read_en = !link.status_output_enable_n ||
        !link.compare_output_enable_n;
    assign link.status_drive = bypass ? sel_st : st_reg;
    assign link.status_drive_en = read_en;
    assign link.result = bypass ? sel_res : res_reg;
    assign link.result_origin_flag = bypass ? out_src : origin_reg;
    assign link.hidden_source_exception = bypass ? hidden_ex : hidden_reg;
endmodule // fes_device
`default_nettype wire

// ---- logic/fes_controller.sv ----
/*
 * Controller end: issues one instruction with operands on request, then
 * enables the status outputs for one cycle and captures what it reads.
 * Assumes the device answers combinationally or one edge later.
 */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
module fes_controller
    import fes_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic i_start,
    input wire logic [`FES_INSTR_W-1:0] i_instruction,
    input wire logic [`FES_DATA_W-1:0] i_a,
    input wire logic [`FES_DATA_W-1:0] i_b,
    input wire logic [1:0] i_view,
    input wire logic i_bypass,
    output logic o_done,
    output logic [`FES_DATA_W-1:0] o_result,
    output logic [`FES_STATUS_W-1:0] o_status,
    output logic o_origin,
    output logic o_hidden,
    fes_link_if.controller link
);
    fes_ctl_state_t state_reg;
    logic [`FES_INSTR_W-1:0] ins_reg;
    logic [`FES_DATA_W-1:0] a_reg, b_reg;
    logic [1:0] view_reg;
    logic bypass_reg, oe_n_reg;

    // Keep B precision equal to A for single-operand floating point ALU ops
    wire single = i_instruction[`FES_UNIT_MSB:`FES_UNIT_LSB] ==
        `FES_SINGLE_OP_UNIT && !i_instruction[`FES_INT_FMT_BIT];
    wire [`FES_INSTR_W-1:0] ins_fixed = single ?
        {i_instruction[10:8], i_instruction[`FES_A_PREC_BIT],
        i_instruction[6:0]} : i_instruction;

    assign link.instruction = ins_reg;
    assign link.port_a_input = a_reg;
    assign link.port_b_input = b_reg;
    assign link.status_view_select = view_reg;
    assign link.output_pipe_bypass = bypass_reg;
    assign link.status_output_enable_n = oe_n_reg;
    assign link.compare_output_enable_n = 1'b1;

    always_ff @(posedge i_clock or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= FES_CTL_IDLE;
            ins_reg <= '0;
            a_reg <= '0;
            b_reg <= '0;
            view_reg <= `FES_VIEW_FOLLOW;
            bypass_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            o_done <= 1'b0;
            o_result <= '0;
            o_status <= '0;
            o_origin <= 1'b0;
            o_hidden <= 1'b0;
        end else begin
            o_done <= 1'b0;
            unique case (state_reg)
                FES_CTL_IDLE: begin
                    if (i_start) begin
                        ins_reg <= ins_fixed;
                        a_reg <= i_a;
                        b_reg <= i_b;
                        view_reg <= i_view;
                        bypass_reg <= i_bypass;
                        state_reg <= FES_CTL_ISSUE;
                    end
                end
                FES_CTL_ISSUE: begin
                    // Wait one edge so a registered status has been taken
                    oe_n_reg <= 1'b0;
                    state_reg <= FES_CTL_READ;
                end
                FES_CTL_READ: begin
                    o_status <= link.status_bus;
                    o_result <= link.result;
                    o_origin <= link.result_origin_flag;
                    o_hidden <= link.hidden_source_exception;
                    oe_n_reg <= 1'b1;
                    o_done <= 1'b1;
                    state_reg <= FES_CTL_IDLE;
                end
                default: state_reg <= FES_CTL_IDLE;
            endcase
        end
    end
endmodule // fes_controller
`default_nettype wire

// ---- tb/fes_link_assertions.sv ----
/* Concurrent checks on the controller-device link signals.
   Assumes one clock domain and an asynchronous active-high reset. */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
module fes_link_assertions
    import fes_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_reset,
    input wire logic [`FES_INSTR_W-1:0] instruction,
    input wire logic [`FES_DATA_W-1:0] port_a_input,
    input wire logic [`FES_DATA_W-1:0] port_b_input,
    input wire logic [1:0] status_view_select,
    input wire logic output_pipe_bypass,
    input wire logic status_output_enable_n,
    input wire logic compare_output_enable_n,
    input wire logic [`FES_DATA_W-1:0] result,
    input wire fes_status_t status_drive,
    input wire logic status_drive_en,
    input wire logic result_origin_flag
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    wire logic [1:0] unit = instruction[`FES_UNIT_MSB:`FES_UNIT_LSB];
    wire logic [3:0] op = instruction[3:0];
    wire logic src = instruction[`FES_OUT_SRC_BIT];
    // Only transparent floating point cycles are judged on data values
    wire logic live = output_pipe_bypass && !instruction[`FES_INT_FMT_BIT];
    wire logic seen = status_drive_en
        && (status_view_select == `FES_VIEW_FOLLOW);
    wire logic move_a = (unit == `FES_SINGLE_OP_UNIT)
        && (op == `FES_OP_MOVE_A) && !src;
    wire logic a_fin = (port_a_input[30:23] != 8'hFF);
    wire logic a_zero = (port_a_input[30:0] == 31'h0);
    wire logic b_zero = (port_b_input[30:0] == 31'h0);
    wire logic sgn = port_a_input[31] ^ port_b_input[31];

    sequence s_reg_capture;
        !output_pipe_bypass ##1 !output_pipe_bypass;
    endsequence

    property p_origin_held;
        s_reg_capture |-> result_origin_flag == $past(src);
    endproperty

    chk_oe_gating: assert property (status_drive_en ==
        (!status_output_enable_n || !compare_output_enable_n))
        else $error("status driven without an enable");
    chk_origin_live: assert property (output_pipe_bypass |->
        result_origin_flag == src)
        else $error("origin flag differs from source bit");
    chk_origin_held: assert property (p_origin_held)
        else $error("registered origin flag wrong");
    chk_move_quiet: assert property (live && move_a && seen |->
        result == port_a_input && status_drive == '0)
        else $error("move A altered data or raised status");
    chk_nan_form: assert property (live && !move_a
        && result[30:23] == 8'hFF && result[22:0] != 23'h0
        |-> result == `FES_NAN_OUT)
        else $error("output NaN not canonical");
    chk_nan_invalid: assert property (live && !move_a && seen
        && result == `FES_NAN_OUT |-> status_drive.invalid_flag)
        else $error("NaN output without invalid flag");
    chk_div_zero: assert property (live && seen && src
        && unit == `FES_DIV_UNIT && op == 4'h0 && b_zero && a_fin && !a_zero
        |-> result == {sgn, 8'hFF, 23'h0} && status_drive.zero_divisor_flag)
        else $error("divide by zero result wrong");
    chk_zero_product: assert property (live && src
        && unit == `FES_MUL_UNIT && op == 4'h0 && a_zero
        && port_b_input[30:23] != 8'hFF |-> result == {sgn, 31'h0})
        else $error("zero product sign wrong");
    chk_inf_flag: assert property (live && seen && !move_a
        && result[30:0] == 31'h7F800000 |-> status_drive.unbounded_result_flag)
        else $error("infinity without its flag");
endmodule // fes_link_assertions
`default_nettype wire

// ---- tb/fpu_exception_status_logic_tb.sv ----
/* Self-checking bench: controller and device joined by the link, driven
   through the controller's user side. Assumes the fes logic files. */
`timescale 1ns/1ps
`include "fes_defs.svh"
`default_nettype none
module fpu_exception_status_logic_tb;
    import fes_pkg::*;
    localparam logic [31:0] NAN = `FES_NAN_OUT;
    localparam logic [31:0] PINF = 32'h7F800000;
    localparam logic [31:0] NINF = 32'hFF800000;
    localparam logic [31:0] TWO = 32'h40000000;
    logic i_clock, i_reset, start, bp, done, org, hid;
    logic [10:0] ins;
    logic [31:0] a, b, res, x;
    logic [1:0] view;
    logic [13:0] st_w;
    fes_status_t st;
    int err_count, checked, cycles;
    // Special-value table: five divides then three multiplies
    logic [31:0] ta[8] = '{32'h0, TWO, PINF, NINF, TWO,
        32'h0, PINF, NINF};
    logic [31:0] tb[8] = '{32'h0, 32'h80000000, PINF, TWO, NINF,
        32'hC0400000, 32'h0, TWO};
    logic [31:0] tr[8] = '{NAN, NINF, NAN, NINF, 32'h80000000,
        32'h80000000, NAN, NINF};
    logic [1:0] tf[8] = '{2'h3, 2'h1, 2'h2, 2'h0, 2'h0, 2'h0, 2'h2, 2'h0};
    assign st = fes_status_t'(st_w);

    fes_link_if link();
    fes_device u_fes_device(.i_clock(i_clock), .i_reset(i_reset),
        .link(link));
    fes_controller u_fes_controller(.i_clock(i_clock), .i_reset(i_reset),
        .i_start(start), .i_instruction(ins), .i_a(a), .i_b(b),
        .i_view(view), .i_bypass(bp), .o_done(done), .o_result(res),
        .o_status(st_w), .o_origin(org), .o_hidden(hid), .link(link));
    fes_link_assertions u_fes_link_assertions(.i_clock(i_clock),
        .i_reset(i_reset), .instruction(link.instruction),
        .port_a_input(link.port_a_input),
        .port_b_input(link.port_b_input),
        .status_view_select(link.status_view_select),
        .output_pipe_bypass(link.output_pipe_bypass),
        .status_output_enable_n(link.status_output_enable_n),
        .compare_output_enable_n(link.compare_output_enable_n),
        .result(link.result), .status_drive(link.status_drive),
        .status_drive_en(link.status_drive_en),
        .result_origin_flag(link.result_origin_flag));

    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end

    function automatic logic [10:0] mk(logic [1:0] u, logic s,
                                       logic [3:0] o);
        logic [10:0] r;
        r = '0;
        r[`FES_UNIT_MSB:`FES_UNIT_LSB] = u;
        r[`FES_OUT_SRC_BIT] = s;
        r[3:0] = o;
        return r;
    endfunction

    function automatic logic [31:0] rnan();
        return {1'($urandom()), 8'hFF, 23'($urandom()) | 23'h1};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkf(input logic [31:0] r, input logic [1:0] f);
        chk(res, r);
        chk({30'h0, st.invalid_flag, st.zero_divisor_flag}, {30'h0, f});
    endtask

    // One operation; bypass drawn at random so both status modes run
    task automatic run(input logic [10:0] in, input logic [31:0] p,
                       input logic [31:0] q, input logic [1:0] v);
        int n;
        @(posedge i_clock);
        #2;
        ins = in;
        a = p;
        b = q;
        view = v;
        bp = 1'($urandom());
        start = 1'b1;
        @(posedge i_clock);
        #2;
        start = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 20) begin
            @(posedge i_clock);
            #2;
            n++;
        end
        chk({31'h0, done}, 32'h1);
    endtask

    task automatic stop_test();
        $display("checks=%0d mismatches=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            stop_test();
        end
    end

    initial begin
        i_reset = 1'b1;
        start = 1'b0;
        ins = '0;
        a = '0;
        b = '0;
        view = 2'h3;
        bp = 1'b0;
        err_count = 0;
        checked = 0;
        cycles = 0;
        void'($urandom(8265));
        repeat (6) @(posedge i_clock);
        #2;
        i_reset = 1'b0;
        for (int i = 0; i < 16; i++) begin
            x = $urandom();
            if (i[0]) begin
                x[31:23] = 9'h001 + 9'($urandom_range(0, 253));
            end
            run(mk(`FES_SINGLE_OP_UNIT, 1'b0, i[0] ? `FES_OP_PASS_A
                : `FES_OP_MOVE_A), x, $urandom(), 2'h3);
            chk(res, x);
            chk({31'h0, org}, 32'h0);
            if (!i[0]) chk({18'h0, st_w}, 32'h0);
        end
        $display("test move and pass done");
        for (int c = 1; c < 4; c++) begin
            run(mk(`FES_MUL_UNIT, 1'b1, 4'h0), c[0] ? rnan() : TWO,
                c[1] ? rnan() : TWO, 2'h2 + 2'($urandom_range(0, 1)));
            chkf(NAN, 2'h2);
            chk({30'h0, st.faulting_port_code}, 32'(c));
            // The ALU sees the same NaN operand and is the hidden unit
            chk({31'h0, hid}, 32'h1);
        end
        run(mk(`FES_SINGLE_OP_UNIT, 1'b0, `FES_OP_PASS_A), rnan(), TWO, 2'h1);
        chkf(NAN, 2'h2);
        chk({30'h0, st.faulting_port_code}, 32'h1);
        chk({31'h0, hid}, 32'h1);
        $display("test nan inputs done");
        for (int i = 0; i < 8; i++) begin
            run(mk(i < 5 ? `FES_DIV_UNIT : `FES_MUL_UNIT, 1'b1, 4'h0),
                ta[i], tb[i], 2'h3);
            chkf(tr[i], tf[i]);
            chk({31'h0, org}, 32'h1);
            chk({31'h0, st.unbounded_result_flag},
                {31'h0, tr[i][30:0] == PINF[30:0]});
        end
        $display("test special values done");
        for (int k = 0; k < 10; k++) begin
            run(mk(`FES_TWO_OP_UNIT, 1'b0, k[2] ? `FES_OP_SUB : `FES_OP_ADD),
                k < 8 ? {k[0], 31'h0} : PINF,
                k < 8 ? {k[1], 31'h0} : {k[0] ^ k[2], PINF[30:0]}, 2'h3);
            if (k < 8) chk(res, {k[0] & (k[1] ^ k[2]), 31'h0});
            else chkf(k[0] ? NAN : PINF, k[0] ? 2'h2 : 2'h0);
        end
        $display("test signed sums done");
        for (int j = 0; j < 2; j++) begin
            run(mk(`FES_SINGLE_OP_UNIT, 1'b0, `FES_OP_PASS_A) | 11'h200,
                j ? 32'h80000005 : 32'h0, 32'h0, 2'h3);
            chk({30'h0, st.equal_zero_flag, st.sign_flag},
                j ? 32'h1 : 32'h2);
        end
        $display("test integer flags done");
        stop_test();
    end
endmodule // fpu_exception_status_logic_tb
`default_nettype wire
